// [inc/sio.sv]
// serial channel constants: register map, field positions, codes
// assumes: used by the channel, its rate generator and the testbench
package sio;
    localparam logic [2:0] A_MODE = 3'h0;
    localparam logic [2:0] A_RATE = 3'h1;
    localparam logic [2:0] A_CTL0 = 3'h2;
    localparam logic [2:0] A_CTL1 = 3'h3;
    localparam logic [2:0] A_TXB  = 3'h4;
    localparam logic [2:0] A_RXB  = 3'h5;
    // mode register: [2:0] operating mode
    localparam int M_EXT   = 3;
    localparam int M_STOP2 = 4;
    localparam int M_EVEN  = 5;
    localparam int M_PAR   = 6;
    localparam int M_OD    = 7;
    localparam logic [2:0] SMD_SYNC = 3'h1;
    localparam logic [2:0] SMD_U7   = 3'h4;
    localparam logic [2:0] SMD_U8   = 3'h5;
    localparam logic [2:0] SMD_U9   = 3'h6;
    // control 0: [1:0] prescaler select
    localparam int C0_RTS  = 2;
    localparam int C0_HOFF = 4;
    localparam int C0_CPOL = 6;
    localparam int C0_MSB  = 7;
    // control 1: [8:7] clock pin select
    localparam int C1_TXEN  = 0;
    localparam int C1_TXE   = 1;
    localparam int C1_RXEN  = 2;
    localparam int C1_RXF   = 3;
    localparam int C1_CAUSE = 4;
    localparam int C1_CONT  = 5;
    localparam int C1_INV   = 6;
    localparam int C1_CKS   = 7;
    // receive buffer read word flags
    localparam int RB_OVR = 12;
    localparam int RB_FER = 13;
    localparam int RB_PER = 14;
    localparam int RB_SUM = 15;
    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic [8:0] CTL1_RST = 9'h000;
    // sixteen oversample ticks per bit, middle at tick eight
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_HALF = 4'h7;
    localparam logic [2:0] PSC8_LAST  = 3'h7;
    localparam logic [4:0] PSC32_LAST = 5'h1f;
    typedef enum logic [1:0] {T_IDLE = 2'b00, T_SYNC = 2'b01,
                              T_UART = 2'b10} tx_st_t;
    typedef enum logic [1:0] {R_IDLE = 2'b00, R_START = 2'b01,
                              R_DATA = 2'b10} rx_st_t;
endpackage

// [rtl/sio_channel.sv]
// serial channel: clock synchronous and asynchronous modes, one channel
// assumes: pins synchronous to clk; pin wires resolved outside
// What this block does
// - data out idles high, or floats if open-drain, until transfer
// - sync transfers need send enable; continuous receive shifts the old buffer out as dummy
// - sync mode: internal clock drives clock pin unless clock pin select is 10, external is input
// - handshake pin: port if disabled, else clear or request to send
// - data in pin is serial input; unused when only sending
// - clock polarity picks launch and sample edges
// - order bit (sync mode only): 0 least significant first, 1 most significant first
// - channel one can route its internal clock to an alternate pin
// - continuous receive: buffer read re-arms reception
// - channel two may invert buffer data on write and read
// - frame: start, 7/8/9 data, optional parity, 1 or 2 stops
// - internal bit rate is prescaled clock over 16(n+1), over 2(n+1) in sync mode
// - external bit rate is pin rate over 16(n+1), the pin rate itself in sync mode; not channel two
// - send starts with enable, full buffer, clear-to-send low
// - receive starts with enable and a start bit
// - cause bit: send request on load or on completion
// - receive request when character enters receive buffer
// - overrun when new character arrives before buffer read
// - overrun overwrites buffer without a new receive request
// - framing error when a stop bit is missing
// - parity error when the ones count mismatches the setting
// - error sum is set by any overrun, framing or parity error
`timescale 1ns/1ps
module sio_channel
#(
    parameter int CHAN = 0
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // register port
    input  wire logic [2:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // serial data pins
    input  wire logic        serial_data_in_pin,
    output logic             serial_data_out_pin,
    output logic             serial_data_out_pin_oe,
    // transfer clock pins
    input  wire logic        transfer_clock_pin_level,
    output logic             transfer_clock_pin_drive,
    output logic             transfer_clock_pin_oe,
    output logic             alternate_clock_pin_drive,
    output logic             alternate_clock_pin_oe,
    // handshake pin
    input  wire logic        handshake_pin_level,
    output logic             handshake_pin_drive,
    output logic             handshake_pin_oe,
    // interrupt requests
    output logic             tx_irq,
    output logic             rx_irq
);
    logic [7:0]  mode, next_mode, rate, next_rate, ctl0, next_ctl0;
    logic [8:0]  ctl1, next_ctl1, txb, next_txb, rxb, next_rxb;
    logic        txe, next_txe, rxf, next_rxf, cont, next_cont;
    logic        ovr, next_ovr, fer, next_fer, per, next_per;
    logic [15:0] next_rdata;
    logic        next_rx_irq, next_tx_irq;
    sio::tx_st_t ts, next_ts;
    sio::rx_st_t rs, next_rs;
    logic [11:0] sh, next_sh, rsh, next_rsh;
    logic [7:0]  rsync, next_rsync;
    logic [3:0]  sub, next_sub, bc, next_bc, rsub, next_rsub;
    logic [3:0]  rbc, next_rbc;
    logic        txd, next_txd, sclk, next_sclk, ckp;
    logic        take, sync_go, sync_load, done, r_done;
    logic        tick, launch, smpl, ld, rd_rx;
    logic [8:0]  ld_data, dmask;
    logic [12:0] frm;
    logic [7:0]  sync_src;

    wire       sync_m = mode[2:0] == sio::SMD_SYNC;
    wire       uart_m = mode[2:0] == sio::SMD_U7 ||
                        mode[2:0] == sio::SMD_U8 ||
                        mode[2:0] == sio::SMD_U9;
    wire [3:0] len = mode[2:0] == sio::SMD_U7 ? 4'h7 :
                     mode[2:0] == sio::SMD_U8 ? 4'h8 : 4'h9;
    wire       pen = mode[sio::M_PAR];
    wire       st2 = mode[sio::M_STOP2];
    // no external clock on channel two
    wire       ext = mode[sio::M_EXT] && CHAN != 2;
    wire       idl = ~ctl0[sio::C0_CPOL];
    wire       msb = ctl0[sio::C0_MSB];
    wire       rts_sel = ctl0[sio::C0_RTS];
    wire       hoff = ctl0[sio::C0_HOFF];
    wire       txen = ctl1[sio::C1_TXEN];
    wire       rxen = ctl1[sio::C1_RXEN];
    wire       inv = ctl1[sio::C1_INV] && CHAN == 2;
    wire       alt = ctl1[sio::C1_CKS + 1] && CHAN == 1;
    wire       ckl = transfer_clock_pin_level;
    wire       rxd = serial_data_in_pin;
    wire [3:0] tlast = len + {3'h0, pen} + 4'h1 + {3'h0, st2};
    wire [3:0] rlast = len + {3'h0, pen} + {3'h0, st2};
    wire       cts_ok = hoff || rts_sel || !handshake_pin_level;

    function automatic logic [7:0] rev8(input logic [7:0] d);
        for (int i = 0; i < 8; i++)
            rev8[i] = d[7 - i];
    endfunction

    function automatic logic [12:0] frame_of(input logic [8:0] d,
        input logic [3:0] n, input logic pe, input logic ev);
        logic [12:0] f;
        logic        p;
        f = 13'h1ffe;
        p = ~ev;
        for (int i = 0; i < 9; i++)
            if (i < int'(n))
            begin
                f[i + 1] = d[i];
                p = p ^ d[i];
            end
        if (pe)
            f[n + 4'h1] = p;
        return f;
    endfunction

    // prescaled or pin source over n+1, sixteen per bit, two per bit in sync mode
    sio_rate_gen u_rate
    (
        .clk      (clk),
        .rstn     (rstn),
        .ce       (ce),
        .psc_sel  (ctl0[1:0]),
        .use_ext  (ext && uart_m),
        .ext_edge (ckl && !ckp),
        .div      (rate),
        .tick     (tick)
    );

    assign frm = frame_of(txb, len, pen, mode[sio::M_EVEN]);
    // ordering applied at buffer to shifter boundary
    assign sync_src = msb ? rev8(txb[7:0]) : txb[7:0];
    assign dmask = len == 4'h7 ? 9'h07f : len == 4'h8 ? 9'h0ff : 9'h1ff;
    // polarity picks launch and sample edges
    assign launch = ext ? (ckp == idl && ckl != idl) : (tick && sclk == idl);
    assign smpl = ext ? (ckp != idl && ckl == idl) : (tick && sclk != idl);

    always_comb
    begin
        next_ts = ts;
        next_sh = sh;
        next_txd = txd;
        next_sub = sub;
        next_bc = bc;
        next_sclk = sclk;
        next_rsync = rsync;
        take = 1'b0;
        sync_go = 1'b0;
        sync_load = 1'b0;
        done = 1'b0;
        case (ts)
            sio::T_IDLE:
            begin
                // line rests high until a transfer begins
                next_txd = 1'b1;
                next_sclk = idl;
                // continuous re-arm reuses old buffer as dummy
                if (sync_m && txen && cts_ok && (!txe || cont) &&
                    (!ext || ckl == idl))
                begin
                    take = !txe;
                    sync_go = 1'b1;
                    next_ts = sio::T_SYNC;
                    next_sh = {4'h0, sync_src};
                    next_bc = 4'h0;
                end
                // enable, full buffer, clear to send
                else if (uart_m && txen && cts_ok && !txe && tick)
                begin
                    take = 1'b1;
                    next_ts = sio::T_UART;
                    next_txd = frm[0];
                    next_sh = frm[12:1];
                    next_sub = 4'h0;
                    next_bc = 4'h0;
                end
            end
            sio::T_SYNC:
            begin
                if (launch)
                begin
                    next_txd = sh[0];
                    next_sh = sh >> 1;
                end
                if (smpl)
                begin
                    next_rsync = {rxd, rsync[7:1]};
                    next_bc = bc + 4'h1;
                    if (bc == 4'h7)
                    begin
                        next_ts = sio::T_IDLE;
                        next_txd = 1'b1;
                        sync_load = 1'b1;
                        done = 1'b1;
                    end
                end
                if (!ext && tick)
                    next_sclk = ~sclk;
            end
            sio::T_UART:
            begin
                if (tick)
                begin
                    next_sub = sub + 4'h1;
                    if (sub == sio::OVS_LAST)
                    begin
                        if (bc == tlast)
                        begin
                            next_ts = sio::T_IDLE;
                            next_txd = 1'b1;
                            done = 1'b1;
                        end
                        else
                        begin
                            next_txd = sh[0];
                            next_sh = sh >> 1;
                            next_bc = bc + 4'h1;
                        end
                    end
                end
            end
            default: next_ts = sio::T_IDLE;
        endcase
        next_tx_irq = ctl1[sio::C1_CAUSE] ? done : take;
    end

    always_comb
    begin
        next_rs = rs;
        next_rsub = rsub;
        next_rbc = rbc;
        next_rsh = rsh;
        r_done = 1'b0;
        case (rs)
            sio::R_IDLE:
            begin
                if (uart_m && rxen && tick && !rxd)
                begin
                    next_rs = sio::R_START;
                    next_rsub = 4'h0;
                end
            end
            sio::R_START:
            begin
                if (tick)
                begin
                    next_rsub = rsub + 4'h1;
                    if (rsub == sio::OVS_HALF)
                    begin
                        next_rs = rxd ? sio::R_IDLE : sio::R_DATA;
                        next_rsub = 4'h0;
                        next_rbc = 4'h0;
                    end
                end
            end
            sio::R_DATA:
            begin
                if (tick)
                begin
                    next_rsub = rsub + 4'h1;
                    if (rsub == sio::OVS_LAST)
                    begin
                        next_rsh[rbc] = rxd;
                        next_rbc = rbc + 4'h1;
                        if (rbc == rlast)
                        begin
                            r_done = 1'b1;
                            next_rs = sio::R_IDLE;
                        end
                    end
                end
            end
            default: next_rs = sio::R_IDLE;
        endcase
        if (!rxen || !uart_m)
            next_rs = sio::R_IDLE;
    end

    // sync capture lands only while reception is enabled
    assign ld = r_done || (sync_load && rxen);
    assign ld_data = r_done ? (next_rsh[8:0] & dmask) :
                     {1'b0, msb ? rev8(next_rsync) : next_rsync};
    assign rd_rx = rd && addr == sio::A_RXB;

    always_comb
    begin
        next_mode = mode;
        next_rate = rate;
        next_ctl0 = ctl0;
        next_ctl1 = ctl1;
        next_txb = txb;
        next_txe = txe;
        next_rxb = rxb;
        next_rxf = rxf;
        next_ovr = ovr;
        next_fer = fer;
        next_per = per;
        next_cont = cont;
        next_rx_irq = 1'b0;
        next_rdata = 16'h0000;
        if (take)
            next_txe = 1'b1;
        if (sync_go)
            next_cont = 1'b0;
        if (!rxen)
        begin
            next_ovr = 1'b0;
            next_fer = 1'b0;
            next_per = 1'b0;
        end
        if (wr)
        begin
            case (addr)
                sio::A_MODE: next_mode = wdata[7:0];
                sio::A_RATE: next_rate = wdata[7:0];
                sio::A_CTL0: next_ctl0 = wdata[7:0];
                sio::A_CTL1: next_ctl1 = wdata[8:0];
                sio::A_TXB:
                begin
                    // inverted on the way into the buffer
                    next_txb = inv ? ~wdata[8:0] : wdata[8:0];
                    next_txe = 1'b0;
                end
                default: next_txe = next_txe;
            endcase
        end
        if (rd_rx)
        begin
            next_rxf = 1'b0;
            // reading the buffer re-arms the next transfer
            if (ctl1[sio::C1_CONT] && rxen && sync_m)
                next_cont = 1'b1;
        end
        if (ld)
        begin
            next_rxb = ld_data;
            next_rxf = 1'b1;
            // full buffer not being read means overrun
            if (rxf && !rd_rx)
                next_ovr = 1'b1;
            // overrun overwrites but raises no request
            // request when character reaches the buffer
            next_rx_irq = !(rxf && !rd_rx);
            // every configured stop bit must be high
            next_fer = r_done && (!next_rsh[len + {3'h0, pen}] ||
                       (st2 && !next_rsh[len + {3'h0, pen} + 4'h1]));
            // parity over character and parity bit
            next_per = r_done && pen && (next_rsh[len] !=
                       (~mode[sio::M_EVEN] ^ (^(next_rsh[8:0] & dmask))));
        end
        if (rd)
        begin
            case (addr)
                sio::A_MODE: next_rdata = {8'h00, mode};
                sio::A_RATE: next_rdata = {8'h00, rate};
                sio::A_CTL0: next_rdata = {8'h00, ctl0};
                sio::A_CTL1: next_rdata = {7'h00, ctl1[8:4], rxf,
                                           ctl1[2], txe, ctl1[0]};
                sio::A_TXB: next_rdata = {7'h00, txb};
                // sum of the three error flags
                sio::A_RXB: next_rdata = {ovr | fer | per, per, fer, ovr,
                                          3'h0, inv ? ~rxb : rxb};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            mode <= sio::REG_RST;
            rate <= sio::REG_RST;
            ctl0 <= sio::REG_RST;
            ctl1 <= sio::CTL1_RST;
            txb <= 9'h000;
            txe <= 1'b1;
            rxb <= 9'h000;
            rxf <= 1'b0;
            {ovr, fer, per, cont} <= 4'h0;
            rdata <= 16'h0000;
            {rx_irq, tx_irq} <= 2'h0;
            ts <= sio::T_IDLE;
            rs <= sio::R_IDLE;
            {sh, rsh} <= 24'h000000;
            rsync <= 8'h00;
            {sub, bc, rsub, rbc} <= 16'h0000;
            {txd, sclk, ckp} <= 3'h7;
        end
        else if (ce)
        begin
            mode <= next_mode;
            rate <= next_rate;
            ctl0 <= next_ctl0;
            ctl1 <= next_ctl1;
            txb <= next_txb;
            txe <= next_txe;
            rxb <= next_rxb;
            rxf <= next_rxf;
            {ovr, fer, per, cont} <= {next_ovr, next_fer, next_per, next_cont};
            rdata <= next_rdata;
            {rx_irq, tx_irq} <= {next_rx_irq, next_tx_irq};
            ts <= next_ts;
            rs <= next_rs;
            {sh, rsh} <= {next_sh, next_rsh};
            rsync <= next_rsync;
            {sub, bc, rsub, rbc} <= {next_sub, next_bc, next_rsub, next_rbc};
            {txd, sclk, ckp} <= {next_txd, next_sclk, ckl};
        end
    end

    // open-drain releases the line instead of driving high
    assign serial_data_out_pin = txd;
    assign serial_data_out_pin_oe = (sync_m || uart_m) &&
                                    !(mode[sio::M_OD] && txd);
    // internal clock drives the pin unless clock pin select is 10, external leaves it input
    // alternate pin takes the clock on channel one only
    assign transfer_clock_pin_drive = sclk;
    assign transfer_clock_pin_oe = sync_m && !ext &&
                                   ctl1[sio::C1_CKS +: 2] != 2'b10;
    assign alternate_clock_pin_drive = sclk;
    assign alternate_clock_pin_oe = sync_m && !ext && alt;
    // port when disabled, request-to-send drives the pin
    // low while a character can still be taken
    assign handshake_pin_oe = !hoff && rts_sel;
    assign handshake_pin_drive = !(rxen && !rxf);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_uart_go;
        ce && ts == sio::T_IDLE && uart_m && take;
    endsequence
    sequence s_sync_end;
        ce && ts == sio::T_SYNC && smpl && bc == 4'h7;
    endsequence

    a_start_bit_low: assert property (s_uart_go |=> !txd && !$past(txe))
        else $error("start bit not driven low");
    a_idle_line_high: assert property (ts == sio::T_IDLE |-> txd)
        else $error("idle data line not high");
    a_cts_blocks_send: assert property (ce && ts == sio::T_IDLE && !hoff
        && !rts_sel && handshake_pin_level |=> ts == sio::T_IDLE)
        else $error("transfer began with clear-to-send high");
    // a buffer write in the take cycle refills the buffer on purpose
    a_load_request: assert property (s_uart_go and !ctl1[sio::C1_CAUSE]
        && !(wr && addr == sio::A_TXB) |=> tx_irq && txe)
        else $error("no send request on buffer load");
    a_sync_eight_bits: assert property (s_sync_end and rxen
        |=> ts == sio::T_IDLE && rxf && txd)
        else $error("sync transfer did not end after eight bits");
    a_overrun_quiet: assert property (ce && ld && rxf && !rd_rx
        |=> ovr && !rx_irq && rxf)
        else $error("overrun raised a receive request");
    a_rx_request: assert property (ce && ld && !rxf |=> rx_irq && rxf)
        else $error("no receive request on buffer load");
    a_false_start: assert property (ce && rs == sio::R_START && tick
        && rsub == sio::OVS_HALF && rxd |=> rs == sio::R_IDLE)
        else $error("glitch accepted as start bit");
    a_bit_sixteen: assert property (ts == sio::T_UART && $past(ts)
        == sio::T_UART && $changed(txd) |-> $past(tick && sub ==
        sio::OVS_LAST))
        else $error("data line changed inside a bit period");
    a_rts_on_full: assert property (ce && ld && rts_sel && !hoff
        |=> handshake_pin_drive)
        else $error("request to send stayed low with full buffer");
endmodule

// [rtl/sio_rate_gen.sv]
// bit rate generator: prescaler f1/f8/f32 or external edges, then n+1
// assumes: ext_edge is a one-cycle pulse synchronous to clk
`timescale 1ns/1ps
module sio_rate_gen
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // source and divider
    input  wire logic [1:0] psc_sel,
    input  wire logic       use_ext,
    input  wire logic       ext_edge,
    input  wire logic [7:0] div,
    // one pulse per divided period
    output logic            tick
);
    logic [4:0] psc;
    logic [4:0] next_psc;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       next_tick;
    logic       src;

    always_comb
    begin
        next_psc = psc + 5'h01;
        case (psc_sel)
            2'b00: src = 1'b1;
            2'b01: src = (psc[2:0] == sio::PSC8_LAST);
            default: src = (psc == sio::PSC32_LAST);
        endcase
        if (use_ext)
            src = ext_edge;
        next_cnt = cnt;
        next_tick = 1'b0;
        if (src)
        begin
            if (cnt == 8'h00)
            begin
                next_cnt = div;
                next_tick = 1'b1;
            end
            else
                next_cnt = cnt - 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            psc <= 5'h00;
            cnt <= 8'h00;
            tick <= 1'b0;
        end
        else if (ce)
        begin
            psc <= next_psc;
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// [verif/remote_peer.sv]
// remote transceiver model: sends asynchronous frames on the data line
// assumes: 16 clk per bit, i.e. divider 0 with the undivided prescaler
`timescale 1ns/1ps
module remote_peer
(
    // clock
    input  wire logic clk,
    // line towards the channel, idles high like a pulled-up wire
    output logic      line
);
    initial line = 1'b1;

    // start, eight data bits lsb first, stop, then one idle bit so that
    // frames may follow back to back without a double drive
    task automatic send(input logic [7:0] d, input logic stop);
        logic [10:0] f;
        f = {1'b1, stop, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            line <= f[i];
            repeat (16) @(posedge clk);
        end
    endtask
endmodule

// [verif/testbench.sv]
// self-checking bench for one serial channel in 8-bit asynchronous and sync modes
// assumes: remote_peer on the data input; clear-to-send held low
`timescale 1ns/1ps
module testbench;
    logic        clk   = 1'b0;
    logic        rstn  = 1'b0;
    logic [2:0]  addr  = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [15:0] rdata;
    logic        line;
    logic        txd;
    logic        txoe;
    logic        rxirq;
    logic        txirq;
    logic        ckoe;
    logic        hsoe;
    logic        hsdrv;
    logic [15:0] v;
    int          n;
    int          err_total = 0;
    int          checked   = 0;

    always #25 clk = ~clk;

    remote_peer u_remote_peer (.clk(clk), .line(line));
    sio_channel u_sio_channel (.clk(clk), .rstn(rstn), .ce(1'b1),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .serial_data_in_pin(line), .serial_data_out_pin(txd),
        .serial_data_out_pin_oe(txoe), .transfer_clock_pin_level(1'b1),
        .transfer_clock_pin_drive(), .transfer_clock_pin_oe(ckoe),
        .alternate_clock_pin_drive(), .alternate_clock_pin_oe(),
        .handshake_pin_level(1'b0), .handshake_pin_drive(hsdrv),
        .handshake_pin_oe(hsoe), .tx_irq(txirq), .rx_irq(rxirq));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // counts receive requests over a window long enough for nf frames
    task automatic recv(input logic [7:0] a, input logic [7:0] b,
                        input logic s, input int nf, output int p);
        p = 0;
        fork
            for (int i = 0; i < nf; i++)
                u_remote_peer.send(i ? b : a, s);
            repeat (nf * 176 + 20)
            begin
                @(negedge clk);
                if (rxirq === 1'b1)
                    p++;
            end
        join
    endtask

    task automatic t_tx;
        logic [9:0] f;
        f = {1'b1, 8'ha5, 1'b0};
        wreg(sio::A_MODE, {13'h0, sio::SMD_U8});
        wreg(sio::A_TXB, 16'h00a5);
        repeat (40) @(negedge clk);
        chk({14'h0, txoe, txd}, 16'h0003);
        wreg(sio::A_CTL1, 16'h0005);
        for (int i = 0; i < 60 && txd !== 1'b0; i++)
            @(negedge clk);
        chk({15'h0, txirq}, 16'h0001);
        repeat (8) @(negedge clk);
        for (int i = 0; i < 10; i++)
        begin
            chk({15'h0, txd}, {15'h0, f[i]});
            repeat (16) @(negedge clk);
        end
    endtask

    // sync mode, internal clock: the idle-high input shifts in as 0xff
    task automatic t_sync;
        wreg(sio::A_CTL1, 16'h0000);
        wreg(sio::A_MODE, {13'h0, sio::SMD_SYNC});
        wreg(sio::A_CTL0, 16'h0004);
        wreg(sio::A_TXB, 16'h005a);
        wreg(sio::A_CTL1, 16'h0005);
        repeat (40) @(negedge clk);
        chk({12'h0, ckoe, hsoe, hsdrv, txd}, 16'h000f);
        rreg(sio::A_RXB, v);
        chk(v, 16'h00ff);
        chk({15'h0, hsdrv}, 16'h0000);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_tx();
        recv(8'h3c, 8'h00, 1'b1, 1, n);
        chk(16'(n), 16'h0001);
        rreg(sio::A_RXB, v);
        chk(v, 16'h003c);
        recv(8'h11, 8'h96, 1'b1, 2, n);
        chk(16'(n), 16'h0001);
        rreg(sio::A_RXB, v);
        chk(v, 16'h9096);
        // overrun flag only clears while reception is off
        wreg(sio::A_CTL1, 16'h0000);
        wreg(sio::A_CTL1, 16'h0004);
        recv(8'h5a, 8'h00, 1'b0, 1, n);
        chk(16'(n), 16'h0001);
        rreg(sio::A_RXB, v);
        chk(v, 16'ha05a);
        t_sync();
        conclude();
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        err_total++;
        conclude();
    end
endmodule
